// File: include/cfg_bank_pkg.sv
// Register map, field positions, reset values and timing for the configuration bank
package cfg_bank_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register addresses (word addresses on the register port)
	localparam logic [3:0] MODE_ADDR = 4'h2;
	localparam logic [3:0] CLOCK_ADDR = 4'h3;
	localparam logic [3:0] GAIN_ADDR = 4'h4;
	localparam logic [3:0] RSVD_ADDR = 4'h5;
	localparam logic [3:0] CFG_ADDR = 4'h6;
	localparam logic [3:0] STATUS_ADDR = 4'h1;

	// Reset values
	localparam logic [15:0] MODE_RST = 16'h0510;
	localparam logic [15:0] CLOCK_RST = 16'h030E;
	localparam logic [15:0] GAIN_RST = 16'h0000;
	localparam logic [15:0] RSVD_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0600;

	// Writable bit masks
	localparam logic [15:0] MODE_WMASK = 16'hFFFF;
	localparam logic [15:0] CLOCK_WMASK = 16'h03FF;
	localparam logic [15:0] GAIN_WMASK = 16'hFFFF;
	localparam logic [15:0] RSVD_WMASK = 16'hFFFF;
	localparam logic [15:0] CFG_WMASK = 16'hFFFF;

	// Mode register fields
	localparam int SRC_SEL_LSB = 2;
	localparam int IDLE_FLOAT_BIT = 1;
	localparam int PULSE_FMT_BIT = 0;

	// Clock register fields
	localparam int CHAN1_EN_BIT = 9;
	localparam int CHAN0_EN_BIT = 8;
	localparam int TURBO_BIT = 5;
	localparam int RATIO_LSB = 2;
	localparam int POWER_LSB = 0;

	// Gain register fields
	localparam int CHAN1_GAIN_LSB = 4;
	localparam int CHAN0_GAIN_LSB = 0;

	// Status flag positions
	localparam int FLAG1_BIT = 1;
	localparam int FLAG0_BIT = 0;

	// Fixed low pulse of the ready pin in pulse format
	localparam int PULSE_NS = 40;
	localparam int CLK_NS = 20;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] PULSE_CYC_W = 4'(PULSE_CYC);

	// Oversampling ratio values
	localparam logic [14:0] RATIO_TURBO = 15'h0040;
	localparam logic [14:0] RATIO_BASE = 15'h0080;
	localparam logic [14:0] RATIO_RST = 15'h0400;

	typedef enum logic [1:0]
	{
		SRC_LAGGING = 2'h0,
		SRC_ANY = 2'h1,
		SRC_LEADING = 2'h2,
		SRC_LEADING_ALT = 2'h3
	} src_sel_t;

	typedef enum logic [1:0]
	{
		POWER_VERY_LOW = 2'h0,
		POWER_LOW = 2'h1,
		POWER_HIGH_RES = 2'h2,
		POWER_HIGH_RES_ALT = 2'h3
	} power_level_t;

endpackage : cfg_bank_pkg

// File: src/cfg_word_reg.sv
// One configuration word with reset value and per-bit write mask
module cfg_word_reg
#(
	parameter logic [15:0] RST_VAL = 16'h0000,
	parameter logic [15:0] WMASK = 16'hFFFF
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] q_o
);

	// Read-only bits keep their reset value whatever the host writes
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q_o <= RST_VAL;
		else if (wr_i)
			q_o <= (wdata_i & WMASK) | (q_o & ~WMASK);
	end

endmodule : cfg_word_reg

// File: src/cfg_register_bank.sv
// Configuration register bank with data-ready pin control
// Notes on behaviour
// (R01) Ready source 00 is the latest enabled channel, 01 any of them, 10 or 11 the earliest.
// (R02) With no result pending the pin is driven high for idle bit 0, released for 1.
// (R03) On new data the pin holds low for format bit 0, or gives one fixed low pulse for 1.
// (R04) Clock bit 9 enables channel 1 and resets set.
// (R05) Clock bit 8 enables channel 0 and resets set.
// (R06) Clock bits 15 to 10 always read zero.
// (R07) Clock bit 5 forces an oversampling ratio of 64, otherwise the ratio field decides.
// (R08) Ratio field bits 4:2 map 000..111 to 128..16384 and reset to 011.
// (R09) Power bits 1:0 give very-low, low, then high resolution for 10 and 11, reset 10.
// (R10) Gain bits 6:4 set channel 1 gain 1 to 128, reset gain 1.
// (R11) Gain bits 2:0 set channel 0 gain 1 to 128, reset gain 1.
// (R12) The host writes zeros to reserved gain and clock bits; the host model clears only gain bits 15:10, 7, 3 and clock bits 7:6.
// (R13) Address 5 is reserved, resets to zero, and the host writes only zeros there.
// (R14) The clock register resets to 030E and the gain register to zero.
// (R15) The register at address 6 resets to 0600.
// (R16) Status bit 1 and bit 0 are the channel 1 and channel 0 new-result flags.
// (R17) Writes leave read-only bits alone and a disabled channel is left out of the source.
module cfg_register_bank
	import cfg_bank_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [cfg_bank_pkg::ADDR_W-1:0] addr_i,
	input wire logic [cfg_bank_pkg::DATA_W-1:0] wdata_i,
	input wire logic chan1_done_i,
	input wire logic chan0_done_i,
	input wire logic result_read_i,
	output logic [cfg_bank_pkg::DATA_W-1:0] rdata_o,
	output logic result_ready_pin_o,
	output logic result_ready_pin_oe_o,
	output logic chan1_enable_o,
	output logic chan0_enable_o,
	output logic [14:0] oversample_ratio_o,
	output logic [1:0] power_level_o,
	output logic [2:0] chan1_amp_gain_o,
	output logic [2:0] chan0_amp_gain_o
);
	import cfg_bank_pkg::*;

	logic [15:0] mode_q;
	logic [15:0] clock_q;
	logic [15:0] gain_q;
	logic [15:0] rsvd_q;
	logic [15:0] cfg_q;
	logic [15:0] status_w;
	logic chan1_new_result_flag_r;
	logic chan0_new_result_flag_r;
	logic seen1_r;
	logic seen0_r;
	logic fire_nxt;
	logic frame_done;
	logic pin_low_nxt;
	logic pending_r;
	logic [3:0] pulse_cnt_r;
	logic [1:0] ready_source_select;
	logic ready_idle_float;
	logic ready_pulse_format;
	logic chan1_enable;
	logic chan0_enable;
	logic turbo_ratio_force;
	logic [2:0] oversample_ratio;
	logic [14:0] ratio_nxt;
	logic ev1;
	logic ev0;

	cfg_word_reg #(.RST_VAL(MODE_RST), .WMASK(MODE_WMASK)) u_mode
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_i && addr_i == MODE_ADDR),
		.wdata_i(wdata_i),
		.q_o(mode_q)
	);

	// Upper bits are read-only zero and keep their value on write [R06] [R17]
	cfg_word_reg #(.RST_VAL(CLOCK_RST), .WMASK(CLOCK_WMASK)) u_clock
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_i && addr_i == CLOCK_ADDR),
		.wdata_i(wdata_i),
		.q_o(clock_q)
	); // [R14]

	// Reserved bits are stored as written; the host model clears gain bits 15:10, 7 and 3 [R12]
	cfg_word_reg #(.RST_VAL(GAIN_RST), .WMASK(GAIN_WMASK)) u_gain
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_i && addr_i == GAIN_ADDR),
		.wdata_i(wdata_i),
		.q_o(gain_q)
	); // [R14]

	cfg_word_reg #(.RST_VAL(RSVD_RST), .WMASK(RSVD_WMASK)) u_rsvd
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_i && addr_i == RSVD_ADDR),
		.wdata_i(wdata_i),
		.q_o(rsvd_q)
	); // [R13]

	cfg_word_reg #(.RST_VAL(CFG_RST), .WMASK(CFG_WMASK)) u_cfg
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_i && addr_i == CFG_ADDR),
		.wdata_i(wdata_i),
		.q_o(cfg_q)
	); // [R15]

	assign ready_source_select = mode_q[SRC_SEL_LSB +: 2];
	assign ready_idle_float = mode_q[IDLE_FLOAT_BIT];
	assign ready_pulse_format = mode_q[PULSE_FMT_BIT];
	assign chan1_enable = clock_q[CHAN1_EN_BIT]; // [R04]
	assign chan0_enable = clock_q[CHAN0_EN_BIT]; // [R05]
	assign turbo_ratio_force = clock_q[TURBO_BIT];
	assign oversample_ratio = clock_q[RATIO_LSB +: 3];

	// Done strobes from a disabled converter are ignored [R17]
	assign ev1 = chan1_done_i && chan1_enable;
	assign ev0 = chan0_done_i && chan0_enable;

	// Ratio is 128 shifted by the code unless turbo forces 64 [R07] [R08]
	always_comb
	begin
		if (turbo_ratio_force)
			ratio_nxt = RATIO_TURBO;
		else
			ratio_nxt = RATIO_BASE << oversample_ratio;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			chan1_enable_o <= CLOCK_RST[CHAN1_EN_BIT];
			chan0_enable_o <= CLOCK_RST[CHAN0_EN_BIT];
			oversample_ratio_o <= RATIO_RST;
			power_level_o <= POWER_HIGH_RES;
			chan1_amp_gain_o <= GAIN_RST[CHAN1_GAIN_LSB +: 3];
			chan0_amp_gain_o <= GAIN_RST[CHAN0_GAIN_LSB +: 3];
		end
		else
		begin
			chan1_enable_o <= chan1_enable; // [R04]
			chan0_enable_o <= chan0_enable; // [R05]
			oversample_ratio_o <= ratio_nxt; // [R07] [R08]
			// Code 11 is folded onto 10 so the analog side sees one high-res code
			if (clock_q[POWER_LSB +: 2] == POWER_HIGH_RES_ALT)
				power_level_o <= POWER_HIGH_RES; // [R09]
			else
				power_level_o <= clock_q[POWER_LSB +: 2]; // [R09]
			chan1_amp_gain_o <= gain_q[CHAN1_GAIN_LSB +: 3]; // [R10]
			chan0_amp_gain_o <= gain_q[CHAN0_GAIN_LSB +: 3]; // [R11]
		end
	end

	// New-result flags; a fresh result wins over a clearing read [R16]
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			chan1_new_result_flag_r <= 1'b0;
			chan0_new_result_flag_r <= 1'b0;
		end
		else
		begin
			if (ev1)
				chan1_new_result_flag_r <= 1'b1; // [R16]
			else if (result_read_i)
				chan1_new_result_flag_r <= 1'b0;
			if (ev0)
				chan0_new_result_flag_r <= 1'b1; // [R16]
			else if (result_read_i)
				chan0_new_result_flag_r <= 1'b0;
		end
	end

	// Per-frame record of which enabled channels have finished
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			seen1_r <= 1'b0;
			seen0_r <= 1'b0;
		end
		else if (frame_done)
		begin
			seen1_r <= 1'b0;
			seen0_r <= 1'b0;
		end
		else
		begin
			seen1_r <= seen1_r | ev1;
			seen0_r <= seen0_r | ev0;
		end
	end

	// A frame closes once every enabled channel has reported; the frame, not a fire,
	// clears the record, so the leading source gives one event per frame [R17]
	assign frame_done = (ev1 || ev0)
		&& (!chan1_enable || seen1_r || ev1)
		&& (!chan0_enable || seen0_r || ev0);

	// Decide when the pin signals new data [R01] [R17]
	always_comb
	begin
		fire_nxt = 1'b0;
		unique case (src_sel_t'(ready_source_select))
			SRC_LAGGING:
				fire_nxt = frame_done;
			SRC_ANY:
				fire_nxt = ev1 || ev0;
			SRC_LEADING, SRC_LEADING_ALT:
				// First enabled channel to finish; later ones of the same frame are ignored
				fire_nxt = (ev1 || ev0) && !seen1_r && !seen0_r;
		endcase
	end

	// Pending holds from the event until the host reads the result [R03]
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pending_r <= 1'b0;
		else if (fire_nxt)
			pending_r <= 1'b1;
		else if (result_read_i)
			pending_r <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pulse_cnt_r <= 4'h0;
		else if (fire_nxt)
			pulse_cnt_r <= PULSE_CYC_W; // [R03]
		else if (pulse_cnt_r != 4'h0)
			pulse_cnt_r <= pulse_cnt_r - 4'h1;
	end

	// Low from a fire, then for the pulse or until the host reads [R03]
	always_comb
	begin
		if (ready_pulse_format)
			pin_low_nxt = fire_nxt || pulse_cnt_r > 4'h1;
		else
			pin_low_nxt = fire_nxt || (pending_r && !result_read_i);
	end

	// Pin drive; a low is always actively driven even in float mode [R02] [R03]
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			result_ready_pin_o <= 1'b1;
			result_ready_pin_oe_o <= 1'b1;
		end
		else
		begin
			result_ready_pin_o <= !pin_low_nxt; // [R03]
			result_ready_pin_oe_o <= pin_low_nxt || !ready_idle_float; // [R02]
		end
	end

	assign status_w = {14'h0000, chan1_new_result_flag_r, chan0_new_result_flag_r};

	// Registered read port; unmapped addresses read zero
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
		begin
			unique case (addr_i)
				STATUS_ADDR: rdata_o <= status_w; // [R16]
				MODE_ADDR: rdata_o <= mode_q;
				CLOCK_ADDR: rdata_o <= clock_q & CLOCK_WMASK; // [R06]
				GAIN_ADDR: rdata_o <= gain_q;
				RSVD_ADDR: rdata_o <= rsvd_q; // [R13]
				CFG_ADDR: rdata_o <= cfg_q;
				default: rdata_o <= 16'h0000;
			endcase
		end
	end

endmodule : cfg_register_bank

// File: sim/cfg_bank_checker.sv
// Port checker for the configuration register bank
module cfg_bank_checker
	import cfg_bank_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [15:0] rdata_o,
	input wire logic result_ready_pin_o,
	input wire logic result_ready_pin_oe_o,
	input wire logic chan1_enable_o,
	input wire logic chan0_enable_o,
	input wire logic [14:0] oversample_ratio_o,
	input wire logic [1:0] power_level_o,
	input wire logic [2:0] chan1_amp_gain_o,
	input wire logic [2:0] chan0_amp_gain_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic wc;
	logic wg;
	assign wc = wr_i && addr_i == CLOCK_ADDR;
	assign wg = wr_i && addr_i == GAIN_ADDR;
	ch1_enable_a: assert property (wc |-> ##2 chan1_enable_o == $past(wdata_i[9], 2))
		else $error("ch1 enable");
	ch0_enable_a: assert property (wc |-> ##2 chan0_enable_o == $past(wdata_i[8], 2))
		else $error("ch0 enable");
	clock_top_zero_a: assert property (rd_i && addr_i == CLOCK_ADDR |=> rdata_o[15:10] == 6'h00)
		else $error("clock top bits");
	turbo_ratio_a: assert property (wc && wdata_i[5] |-> ##2 oversample_ratio_o == 15'h0040)
		else $error("turbo ratio");
	ratio_map_a: assert property (wc && !wdata_i[5] |-> ##2
		oversample_ratio_o == (15'h0080 << $past(wdata_i[4:2], 2))) else $error("ratio map");
	power_fold_a: assert property (wc |-> ##2 power_level_o ==
		{$past(wdata_i[1], 2), $past(wdata_i[0] & !wdata_i[1], 2)}) else $error("power");
	gain_one_a: assert property (wg |-> ##2 chan1_amp_gain_o == $past(wdata_i[6:4], 2))
		else $error("gain 1");
	gain_zero_a: assert property (wg |-> ##2 chan0_amp_gain_o == $past(wdata_i[2:0], 2))
		else $error("gain 0");
	low_driven_a: assert property (!result_ready_pin_o |-> result_ready_pin_oe_o)
		else $error("ready low not driven");
endmodule : cfg_bank_checker

bind cfg_register_bank cfg_bank_checker chk (.clk_i, .rst_n_i, .wr_i, .rd_i, .addr_i,
	.wdata_i, .rdata_o, .result_ready_pin_o, .result_ready_pin_oe_o, .chan1_enable_o,
	.chan0_enable_o, .oversample_ratio_o, .power_level_o, .chan1_amp_gain_o,
	.chan0_amp_gain_o);

// File: sim/host_model.sv
// Host controller model: register port and result acknowledge
module host_model
	import cfg_bank_pkg::*;
(
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [3:0] addr_o,
	output logic [15:0] wdata_o,
	output logic ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 4'h0;
		wdata_o = 16'h0000;
		ack_o = 1'b0;
	end
	task automatic put(input logic [3:0] a, input logic [15:0] d, output logic [15:0] v);
		v = d;
		if (a == GAIN_ADDR)
			v = v & 16'h0377;
		if (a == CLOCK_ADDR)
			v = v & 16'hFF3F;
		if (a == RSVD_ADDR)
			v = 16'h0000;
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// Released data is scrambled so a stale value cannot pass
		wdata_o <= ~v;
	endtask : put
	task automatic get(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask : get
	task automatic acknowledge();
		@(posedge clk_i);
		ack_o <= 1'b1;
		@(posedge clk_i);
		ack_o <= 1'b0;
		repeat (2) @(negedge clk_i);
	endtask : acknowledge
endmodule : host_model

// File: sim/cfg_register_bank_tb.sv
// Self-checking bench for the configuration register bank
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module cfg_register_bank_tb
	import cfg_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ch1 = 1'b0;
	logic ch0 = 1'b0;
	logic wr;
	logic rd;
	logic ack;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic pin;
	logic oe;
	logic en1;
	logic en0;
	logic [14:0] ratio;
	logic [1:0] power_level;
	logic [2:0] g1;
	logic [2:0] g0;
	int n_errors = 0;
	int tests_run = 0;
	int m[8];
	int f;
	logic [15:0] r;
	logic [15:0] v;
	always #10 clk_i = ~clk_i;
	host_model host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata), .ack_o(ack));
	cfg_register_bank dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr), .rd_i(rd), .addr_i(addr),
		.wdata_i(wdata), .chan1_done_i(ch1), .chan0_done_i(ch0), .result_read_i(ack),
		.rdata_o(rdata), .result_ready_pin_o(pin), .result_ready_pin_oe_o(oe),
		.chan1_enable_o(en1), .chan0_enable_o(en0), .oversample_ratio_o(ratio),
		.power_level_o(power_level), .chan1_amp_gain_o(g1), .chan0_amp_gain_o(g0));
	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		m = '{0, 0, 'h0510, 'h030E, 0, 0, 'h0600, 0};
		f = 0;
	endtask : do_reset
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		host.put(a, d, v);
		if (a > 1 && a < 7)
			m[a] = (a == CLOCK_ADDR) ? v & 'h03FF : v;
	endtask : wr_reg
	task automatic chk_reg(input logic [3:0] a);
		host.get(a, r);
		`CHK(r, 16'(a == STATUS_ADDR ? f : m[a]))
	endtask : chk_reg
	task automatic chk_out();
		int c;
		c = m[3];
		`CHK(en1, c[9])
		`CHK(en0, c[8])
		`CHK(ratio, 15'(c[5] ? 64 : 128 << c[4:2]))
		`CHK(power_level, 2'(c[1:0] == 3 ? 2 : c[1:0]))
		`CHK(g1, m[4][6:4])
		`CHK(g0, m[4][2:0])
	endtask : chk_out
	task automatic fire(input logic a, input logic b);
		@(posedge clk_i);
		ch1 <= a;
		ch0 <= b;
		@(posedge clk_i);
		ch1 <= 1'b0;
		ch0 <= 1'b0;
		@(negedge clk_i);
	endtask : fire
	task automatic results();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial
	begin
		void'($urandom(16174));
		do_reset();
		for (int a = 0; a < 8; a++)
			chk_reg(4'(a));
		chk_out();
		for (int i = 0; i < 16; i++)
		begin
			wr_reg(CLOCK_ADDR, 16'($urandom & 'hFFC0 | (i % 8) << 2 | (i / 8) << 5 | i % 4));
			wr_reg(GAIN_ADDR, 16'($urandom & 'hFF88 | (i % 8) * 17));
			chk_reg(CLOCK_ADDR);
			chk_reg(GAIN_ADDR);
			chk_out();
		end
		for (int a = 1; a < 8; a += 2)
			wr_reg(4'(a), 16'($urandom));
		for (int a = 0; a < 8; a++)
			chk_reg(4'(a));
		for (int s = 0; s < 4; s++)
		begin
			do_reset();
			wr_reg(MODE_ADDR, 16'(s << 2));
			fire(1'b0, 1'b1);
			`CHK({pin, oe}, {s == 0, 1'b1})
			f = 1;
			chk_reg(STATUS_ADDR);
			fire(1'b1, 1'b0);
			`CHK(pin, 1'b0)
			host.acknowledge();
			f = 0;
			`CHK({pin, oe}, 2'h3)
		end
		do_reset();
		wr_reg(CLOCK_ADDR, 16'h010E);
		wr_reg(MODE_ADDR, 16'h0003);
		repeat (2) @(negedge clk_i);
		`CHK(oe, 1'b0)
		fire(1'b1, 1'b0);
		`CHK(oe, 1'b0)
		fire(1'b0, 1'b1);
		`CHK({pin, oe}, 2'h1)
		@(negedge clk_i);
		`CHK({pin, oe}, 2'h1)
		@(negedge clk_i);
		`CHK(oe, 1'b0)
		// Pulse format: any-channel pulses for every channel, earliest once per frame
		for (int s = 1; s < 3; s++)
		begin
			do_reset();
			wr_reg(MODE_ADDR, 16'(s << 2 | 1));
			fire(1'b0, 1'b1);
			`CHK(pin, 1'b0)
			fire(1'b1, 1'b0);
			`CHK(pin, s == 2)
			fire(1'b0, 1'b1);
			`CHK(pin, 1'b0)
		end
		results();
	end
endmodule : cfg_register_bank_tb
